// ### verilog/exchange_side_end.sv
// Operation
// [R1] both sides may send the sequence element
// [R2] sequence element only in three message classes
// [R3] sequence element is three octets, binary
// [R4] send count, or receive count in acks
// [R5] ringing element travels exchange to access only
// [R6] ringing element is three octets long
// [R7] pulse type uses the defined downward codes
// [R8] duration field is an index, not time
// [R9] suppression field two bits, four codes
// [R10] acknowledge field two bits, four codes
// [R11] pulse count of zero is invalid
// [R12] pulsed element three to five octets
// [R13] exchange commands pulses, access reports them
// [R14] steady element three octets, type octet three
// [R15] exchange commands steady, access reports it
// [R16] steady codes defined, two gap codes invalid
// [R17] ringing type is a binary index
// [R18] octet one identifier, octet two length
// [R19] bit eight marks the final octet; the code also sets it on octet three of four- and five-octet pulsed elements
`timescale 1ns/1ns
`default_nettype none
module exchange_side_end (
  input wire logic clk,
  input wire logic rst_n,
  pstn_ie_link.exchange_end link,
  // element to send: a command towards the line
  input wire logic tx_req,
  input wire pstn_ie_pkg::ie_req_t tx,
  output logic tx_ready,
  output logic tx_reject,
  // message class around the element being received
  input wire pstn_ie_pkg::msg_class_t rx_msg,
  output logic rx_valid,
  output logic rx_error,
  output pstn_ie_pkg::ie_fields_t rx_fields
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pstn_ie_pkg::tx_state_t tx_state; // transmit phase
    pstn_ie_pkg::octets_t oct; // octets still to go, head in slot 0
    logic [2:0] left; // octets left including head
    logic reject; // one-cycle refusal pulse
    pstn_ie_pkg::octets_t rbuf; // octets gathered so far
    logic [2:0] rcnt; // octets gathered so far
    logic rovf; // more octets than any element holds
    logic rvalid; // one-cycle element pulse
    logic rerr; // element broken
    pstn_ie_pkg::ie_fields_t rf; // decoded fields
  } state_t;

  state_t st; // registered state
  state_t next_st; // next state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // all work of both directions is folded into one pass
  always_comb begin
    pstn_ie_pkg::octets_t b;
    logic [2:0] c;
    b = st.rbuf;
    c = st.rcnt;
    next_st = st;
    next_st.reject = 1'b0;
    next_st.rvalid = 1'b0;

    // transmit: take a request only while idle
    case (st.tx_state)
      pstn_ie_pkg::TX_IDLE: begin
        if (tx_req) begin
          // [R2] [R5] [R7] [R11] [R12] [R16] refuse bad content
          if (pstn_ie_pkg::req_error(tx, 1'b0)) begin
            next_st.reject = 1'b1;
          end else begin
            // [R1] [R3] [R4] [R6] [R14] [R18] [R19] build the octets
            // [R8] [R9] [R10] [R17] fields pass as given
            // [R13] [R15] outgoing elements are commands to the port
            next_st.oct = pstn_ie_pkg::encode(tx);
            next_st.left = pstn_ie_pkg::ie_octets(tx);
            next_st.tx_state = pstn_ie_pkg::TX_SEND;
          end
        end
      end
      pstn_ie_pkg::TX_SEND: begin
        // shift so the data output always comes straight from a flop
        if (link.x2a_ready) begin
          next_st.oct = {8'h00, st.oct[4:1]};
          next_st.left = st.left - 3'd1;
          if (st.left == 3'd1) begin
            next_st.tx_state = pstn_ie_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        next_st.tx_state = pstn_ie_pkg::TX_IDLE;
      end
    endcase

    // receive: gather octets until the last flag
    if (link.a2x_valid) begin
      if (st.rcnt < pstn_ie_pkg::MAX_OCTETS) begin
        b[st.rcnt] = link.a2x_data;
        c = st.rcnt + 3'd1;
      end else begin
        // an overlong element is kept out of the buffer and marked
        next_st.rovf = 1'b1;
      end
      next_st.rbuf = b;
      next_st.rcnt = c;
      if (link.a2x_last) begin
        next_st.rvalid = 1'b1;
        // [R3] [R5] [R6] [R7] [R11] [R12] [R14] [R16] [R18] [R19] check it
        // ringing from the access side is refused here
        next_st.rerr = next_st.rovf || pstn_ie_pkg::check(b, c, 1'b1, rx_msg);
        // [R4] [R13] [R15] incoming elements are reports from the port
        next_st.rf = pstn_ie_pkg::fields(b, c, rx_msg);
        next_st.rbuf = '0;
        next_st.rcnt = 3'd0;
        next_st.rovf = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // ready is combinational, data comes from the head flop
  assign tx_ready = (st.tx_state == pstn_ie_pkg::TX_IDLE);
  assign tx_reject = st.reject;
  assign link.x2a_valid = (st.tx_state == pstn_ie_pkg::TX_SEND);
  assign link.x2a_data = st.oct[0];
  assign link.x2a_last = (st.tx_state == pstn_ie_pkg::TX_SEND) && (st.left == 3'd1);
  // no buffering: every octet is taken the cycle it is offered
  assign link.a2x_ready = 1'b1;
  assign rx_valid = st.rvalid;
  assign rx_error = st.rerr;
  assign rx_fields = st.rf;
endmodule // exchange_side_end
`default_nettype wire

// ### verilog/pstn_ie_pkg.sv
`default_nettype none
package pstn_ie_pkg;
  // ----------------------------------------
  // element identifiers and octet layout
  // ----------------------------------------
  localparam logic [7:0] ID_SEQ = 8'h00;
  localparam logic [7:0] ID_RING = 8'h01;
  localparam logic [7:0] ID_PULSE = 8'h02;
  localparam logic [7:0] ID_STEADY = 8'h03;
  localparam logic [2:0] FIXED_OCTETS = 3'h3;
  localparam logic [2:0] MIN_OCTETS = 3'h3;
  localparam logic [2:0] MAX_OCTETS = 3'h5;
  localparam logic [2:0] HEAD_OCTETS = 3'h2;
  localparam int EXT_BIT = 7;
  // ----------------------------------------
  // code ranges
  // ----------------------------------------
  localparam logic [6:0] PULSE_TYPE_MIN = 7'h6b;
  localparam logic [6:0] STEADY_TYPE_MAX = 7'h1e;
  localparam logic [6:0] STEADY_GAP_LO = 7'h1b;
  localparam logic [6:0] STEADY_GAP_HI = 7'h1c;
  localparam logic [4:0] NPULSE_ZERO = 5'h00;

  // element kind, equal to the identifier low bits
  typedef enum logic [1:0] {
    IE_SEQ = 2'b00,
    IE_RING = 2'b01,
    IE_PULSE = 2'b10,
    IE_STEADY = 2'b11
  } ie_kind_t;

  // class of the message that carries the element
  typedef enum logic [1:0] {
    MSG_SIGNAL = 2'b00,
    MSG_PROT_PARAM = 2'b01,
    MSG_SIGNAL_ACK = 2'b11,
    MSG_OTHER = 2'b10
  } msg_class_t;

  // transmit path states
  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

  // element request from the user side
  typedef struct packed {
    ie_kind_t kind;
    msg_class_t msg;
    logic [6:0] send_count;
    logic [6:0] recv_count;
    logic [6:0] code;
    logic [4:0] dur;
    logic [1:0] supp;
    logic [1:0] ack;
    logic [4:0] npulse;
    logic [1:0] opt;
  } ie_req_t;

  // decoded element towards the user side
  typedef struct packed {
    ie_kind_t kind;
    logic seq_is_recv;
    logic [6:0] code;
    logic [4:0] dur;
    logic [1:0] supp;
    logic [1:0] ack;
    logic [4:0] npulse;
    logic [2:0] octets;
  } ie_fields_t;

  typedef logic [4:0][7:0] octets_t;

  function automatic logic pulse_type_ok(input logic [6:0] c);
    return c >= PULSE_TYPE_MIN;
  endfunction

  function automatic logic steady_type_ok(input logic [6:0] c);
    return (c <= STEADY_TYPE_MAX) && (c != STEADY_GAP_LO) && (c != STEADY_GAP_HI);
  endfunction

  function automatic logic [2:0] ie_octets(input ie_req_t r);
    return (r.kind == IE_PULSE) ? 3'(FIXED_OCTETS + {1'b0, r.opt}) : FIXED_OCTETS;
  endfunction

  // request that must not leave this end
  function automatic logic req_error(input ie_req_t r, input logic from_access);
    logic e;
    e = 1'b0;
    if (r.kind == IE_SEQ && r.msg == MSG_OTHER) e = 1'b1;
    if (r.kind == IE_RING && from_access) e = 1'b1;
    if (r.kind == IE_PULSE) begin
      if (!pulse_type_ok(r.code) || r.opt > 2'd2) e = 1'b1;
      if (r.opt == 2'd2 && r.npulse == NPULSE_ZERO) e = 1'b1;
    end
    if (r.kind == IE_STEADY && !steady_type_ok(r.code)) e = 1'b1;
    return e;
  endfunction

  // build octets, first octet in slot 0
  function automatic octets_t encode(input ie_req_t r);
    octets_t o;
    logic [6:0] v;
    o = '0;
    v = (r.kind != IE_SEQ) ? r.code : (r.msg == MSG_SIGNAL_ACK) ? r.recv_count : r.send_count;
    o[0] = {6'h00, r.kind};
    o[1] = {5'h00, 3'(ie_octets(r) - HEAD_OCTETS)};
    o[2] = {1'b1, v};
    o[3] = {r.opt != 2'd2, r.supp, r.dur};
    o[4] = {1'b1, r.ack, r.npulse};
    return o;
  endfunction

  // check a received element of c octets
  function automatic logic check(input octets_t b, input logic [2:0] c,
                                 input logic from_access, input msg_class_t m);
    logic e;
    e = (c < MIN_OCTETS) || (c > MAX_OCTETS) || (b[0][7:2] != 6'h00);
    if (b[1] != {5'h00, 3'(c - HEAD_OCTETS)} || !b[2][EXT_BIT]) e = 1'b1;
    case (ie_kind_t'(b[0][1:0]))
      IE_SEQ: e = e || (c != FIXED_OCTETS) || (m == MSG_OTHER);
      IE_RING: e = e || (c != FIXED_OCTETS) || from_access;
      IE_PULSE: begin
        e = e || !pulse_type_ok(b[2][6:0]);
        if (c >= 3'd4 && b[3][EXT_BIT] != (c == 3'd4)) e = 1'b1;
        if (c == MAX_OCTETS && (!b[4][EXT_BIT] || b[4][4:0] == NPULSE_ZERO)) e = 1'b1;
      end
      default: e = e || (c != FIXED_OCTETS) || !steady_type_ok(b[2][6:0]);
    endcase
    return e;
  endfunction

  // lift fields out of a received element
  function automatic ie_fields_t fields(input octets_t b, input logic [2:0] c,
                                        input msg_class_t m);
    ie_fields_t f;
    f = '0;
    f.kind = ie_kind_t'(b[0][1:0]);
    f.seq_is_recv = (m == MSG_SIGNAL_ACK);
    f.code = b[2][6:0];
    f.octets = c;
    if (c >= 3'd4) begin
      f.supp = b[3][6:5];
      f.dur = b[3][4:0];
    end
    if (c == MAX_OCTETS) begin
      f.ack = b[4][6:5];
      f.npulse = b[4][4:0];
    end
    return f;
  endfunction
endpackage
`default_nettype wire

// ### verilog/pstn_ie_link.sv
`timescale 1ns/1ns
`default_nettype none
// octet streams in both directions, last marks the final octet of an element
interface pstn_ie_link;
  logic x2a_valid;
  logic x2a_ready;
  logic [7:0] x2a_data;
  logic x2a_last;
  logic a2x_valid;
  logic a2x_ready;
  logic [7:0] a2x_data;
  logic a2x_last;
  modport exchange_end (
    output x2a_valid, x2a_data, x2a_last, a2x_ready,
    input x2a_ready, a2x_valid, a2x_data, a2x_last
  );
  modport access_end (
    output a2x_valid, a2x_data, a2x_last, x2a_ready,
    input a2x_ready, x2a_valid, x2a_data, x2a_last
  );
endinterface
`default_nettype wire

// ### verilog/access_side_end.sv
`timescale 1ns/1ns
`default_nettype none
module access_side_end (
  input wire logic clk,
  input wire logic rst_n,
  pstn_ie_link.access_end link,
  // element to send: a report of what the subscriber did
  input wire logic tx_req,
  input wire pstn_ie_pkg::ie_req_t tx,
  output logic tx_ready,
  output logic tx_reject,
  // message class around the element being received
  input wire pstn_ie_pkg::msg_class_t rx_msg,
  output logic rx_valid,
  output logic rx_error,
  output pstn_ie_pkg::ie_fields_t rx_fields
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pstn_ie_pkg::tx_state_t tx_state; // transmit phase
    pstn_ie_pkg::octets_t oct; // octets still to go
    logic [2:0] left; // octets left including head
    logic reject; // one-cycle refusal pulse
    pstn_ie_pkg::octets_t rbuf; // octets gathered
    logic [2:0] rcnt; // count gathered
    logic rovf; // overlong element
    logic rvalid; // one-cycle element pulse
    logic rerr; // element broken
    pstn_ie_pkg::ie_fields_t rf; // decoded fields
  } state_t;

  state_t st; // registered state
  state_t next_st; // next state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    pstn_ie_pkg::octets_t b;
    logic [2:0] c;
    b = st.rbuf;
    c = st.rcnt;
    next_st = st;
    next_st.reject = 1'b0;
    next_st.rvalid = 1'b0;

    case (st.tx_state)
      pstn_ie_pkg::TX_IDLE: begin
        if (tx_req) begin
          // [R5] this end never emits ringing
          if (pstn_ie_pkg::req_error(tx, 1'b1)) begin
            next_st.reject = 1'b1;
          end else begin
            // [R13] [R15] outgoing elements report subscriber signals
            next_st.oct = pstn_ie_pkg::encode(tx);
            next_st.left = pstn_ie_pkg::ie_octets(tx);
            next_st.tx_state = pstn_ie_pkg::TX_SEND;
          end
        end
      end
      pstn_ie_pkg::TX_SEND: begin
        if (link.a2x_ready) begin
          next_st.oct = {8'h00, st.oct[4:1]};
          next_st.left = st.left - 3'd1;
          if (st.left == 3'd1) begin
            next_st.tx_state = pstn_ie_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        next_st.tx_state = pstn_ie_pkg::TX_IDLE;
      end
    endcase

    // receive: ringing is legal in this direction
    if (link.x2a_valid) begin
      if (st.rcnt < pstn_ie_pkg::MAX_OCTETS) begin
        b[st.rcnt] = link.x2a_data;
        c = st.rcnt + 3'd1;
      end else begin
        next_st.rovf = 1'b1;
      end
      next_st.rbuf = b;
      next_st.rcnt = c;
      if (link.x2a_last) begin
        next_st.rvalid = 1'b1;
        // [R12] [R18] [R19] check the element from the exchange side
        next_st.rerr = next_st.rovf || pstn_ie_pkg::check(b, c, 1'b0, rx_msg);
        next_st.rf = pstn_ie_pkg::fields(b, c, rx_msg);
        next_st.rbuf = '0;
        next_st.rcnt = 3'd0;
        next_st.rovf = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign tx_ready = (st.tx_state == pstn_ie_pkg::TX_IDLE);
  assign tx_reject = st.reject;
  assign link.a2x_valid = (st.tx_state == pstn_ie_pkg::TX_SEND);
  assign link.a2x_data = st.oct[0];
  assign link.a2x_last = (st.tx_state == pstn_ie_pkg::TX_SEND) && (st.left == 3'd1);
  assign link.x2a_ready = 1'b1;
  assign rx_valid = st.rvalid;
  assign rx_error = st.rerr;
  assign rx_fields = st.rf;
endmodule // access_side_end
`default_nettype wire

// ### verif/pstn_variable_ie_codec_checker.sv
`timescale 1ns/1ns
`default_nettype none
// watches both octet streams of one link
module pstn_variable_ie_codec_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic x2a_valid,
  input wire logic x2a_ready,
  input wire logic [7:0] x2a_data,
  input wire logic x2a_last,
  input wire logic a2x_valid,
  input wire logic a2x_ready,
  input wire logic [7:0] a2x_data,
  input wire logic a2x_last
);
  // ----------------------------------------
  // octet position, kind and length in flight
  // ----------------------------------------
  logic [2:0] xc; // octet index, exchange to access
  logic [2:0] ac; // octet index, access to exchange
  logic [1:0] xk; // kind of the element in flight
  logic [7:0] xl; // length octet of the element in flight
  // index restarts after last, so a stray octet shows as a new head
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xc <= 3'h0;
      ac <= 3'h0;
      xk <= 2'h0;
      xl <= 8'h00;
    end else begin
      if (x2a_valid && x2a_ready) xc <= x2a_last ? 3'h0 : 3'(xc + 3'h1);
      if (x2a_valid && x2a_ready && xc == 3'h0) xk <= x2a_data[1:0];
      if (x2a_valid && x2a_ready && xc == 3'h1) xl <= x2a_data;
      if (a2x_valid && a2x_ready) ac <= a2x_last ? 3'h0 : 3'(ac + 3'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // element framing
  // ----------------------------------------
  sequence s_x_open;
    x2a_valid && xc == 3'h0;
  endsequence
  sequence s_x_body;
    x2a_valid [*2];
  endsequence
  property p_x_run;
    s_x_open |=> s_x_body;
  endproperty
  a_x_run: assert property (p_x_run) else $error("element shorter than three octets");
  property p_x_head;
    x2a_valid && xc == 3'h0 |-> x2a_data[7:2] == 6'h00;
  endproperty
  a_x_head: assert property (p_x_head) else $error("bad identifier octet");
  property p_x_fixlen;
    x2a_valid && xc == 3'h1 && xk != 2'h2 |-> x2a_data == 8'h01;
  endproperty
  a_x_fixlen: assert property (p_x_fixlen) else $error("fixed element length wrong");
  property p_x_plen;
    x2a_valid && xc == 3'h1 && xk == 2'h2 |-> x2a_data inside {[8'h01:8'h03]};
  endproperty
  a_x_plen: assert property (p_x_plen) else $error("pulsed length out of range");
  property p_x_last;
    x2a_valid && x2a_last |-> xc >= 3'h2 && xc == 3'(xl[2:0] + 3'h1);
  endproperty
  a_x_last: assert property (p_x_last) else $error("last octet disagrees with length");
  // ----------------------------------------
  // content octets, and no ringing identifier from the access side
  // ----------------------------------------
  property p_x_ext3;
    x2a_valid && xc == 3'h2 |-> x2a_data[7];
  endproperty
  a_x_ext3: assert property (p_x_ext3) else $error("octet three flag low");
  property p_x_pcode;
    x2a_valid && xc == 3'h2 && xk == 2'h2 |-> x2a_data[6:0] >= 7'h6b;
  endproperty
  a_x_pcode: assert property (p_x_pcode) else $error("undefined pulse type sent");
  property p_x_scode;
    x2a_valid && xc == 3'h2 && xk == 2'h3 |-> x2a_data[6:0] <= 7'h1e
      && x2a_data[6:0] != 7'h1b && x2a_data[6:0] != 7'h1c;
  endproperty
  a_x_scode: assert property (p_x_scode) else $error("undefined steady type sent");
  property p_x_ext4;
    x2a_valid && xc == 3'h3 |-> x2a_data[7] == x2a_last;
  endproperty
  a_x_ext4: assert property (p_x_ext4) else $error("octet four flag wrong");
  property p_x_npulse;
    x2a_valid && xc == 3'h4 |-> x2a_data[4:0] != 5'h00 && x2a_data[7] && x2a_last;
  endproperty
  a_x_npulse: assert property (p_x_npulse) else $error("bad pulse count octet");
  property p_a_ring;
    a2x_valid && ac == 3'h0 |-> a2x_data != 8'h01;
  endproperty
  a_a_ring: assert property (p_a_ring) else $error("ringing sent by access side");
endmodule // pstn_variable_ie_codec_checker
`default_nettype wire

// ### verif/pstn_variable_ie_codec_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pstn_variable_ie_codec_tb;
  // ----------------------------------------
  // clock, user sides and links
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic x_req, a_req, x_rdy, a_rdy, x_rej, a_rej, x_rv, a_rv, b_rv, x_re, a_re, b_re;
  pstn_ie_pkg::ie_req_t x_tx, a_tx;
  pstn_ie_pkg::msg_class_t x_msg, a_msg, b_msg;
  pstn_ie_pkg::ie_fields_t x_rf, a_rf, b_rf;
  logic [7:0] xq[$], aq[$]; // octets seen on the wire
  logic [7:0] st[7] = '{8'h00, 8'h1a, 8'h1d, 8'h1e, 8'h9b, 8'h9c, 8'h9f}; // top bit: refused
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  pstn_ie_link lk();
  pstn_ie_link lk2(); // second link: the bench plays a faulty access side
  always #5 clk = ~clk;
  exchange_side_end i_exchange_side_end (.clk(clk), .rst_n(rst_n), .link(lk), .tx_req(x_req),
    .tx(x_tx), .tx_ready(x_rdy), .tx_reject(x_rej), .rx_msg(x_msg), .rx_valid(x_rv),
    .rx_error(x_re), .rx_fields(x_rf));
  access_side_end i_access_side_end (.clk(clk), .rst_n(rst_n), .link(lk), .tx_req(a_req),
    .tx(a_tx), .tx_ready(a_rdy), .tx_reject(a_rej), .rx_msg(a_msg), .rx_valid(a_rv),
    .rx_error(a_re), .rx_fields(a_rf));
  exchange_side_end i_exchange_side_end_b (.clk(clk), .rst_n(rst_n), .link(lk2), .tx_req(1'b0),
    .tx('0), .tx_ready(), .tx_reject(), .rx_msg(b_msg), .rx_valid(b_rv), .rx_error(b_re),
    .rx_fields(b_rf));
  pstn_variable_ie_codec_checker i_chk (.clk(clk), .rst_n(rst_n), .x2a_valid(lk.x2a_valid),
    .x2a_ready(lk.x2a_ready), .x2a_data(lk.x2a_data), .x2a_last(lk.x2a_last),
    .a2x_valid(lk.a2x_valid), .a2x_ready(lk.a2x_ready), .a2x_data(lk.a2x_data),
    .a2x_last(lk.a2x_last));
  // wire monitor and hang guard
  always @(posedge clk) begin
    if (lk.x2a_valid && lk.x2a_ready) xq.push_back(lk.x2a_data);
    if (lk.a2x_valid && lk.a2x_ready) aq.push_back(lk.a2x_data);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // bounded wait for a completed element: 0 exchange, 1 access, 2 faulty link
  task automatic wv(input int s);
    for (int i = 0; i < 12; i++) begin
      #1;
      if ((s == 0 && x_rv) || (s == 1 && a_rv) || (s == 2 && b_rv)) break;
      @(posedge clk);
    end
  endtask
  // one element end to end; kind and class as raw codes
  task automatic run(input logic fa, input logic [1:0] k, input logic [1:0] m,
                     input logic [6:0] c, input logic [1:0] o, input logic [4:0] np,
                     input logic [1:0] sa, input logic rj);
    pstn_ie_pkg::ie_req_t r;
    pstn_ie_pkg::ie_fields_t f;
    logic [7:0] q[$];
    r = '0;
    r.kind = pstn_ie_pkg::ie_kind_t'(k);
    r.msg = pstn_ie_pkg::msg_class_t'(m);
    r.send_count = 7'h11;
    r.recv_count = 7'h22;
    r.code = c;
    r.dur = 5'h0a;
    r.supp = sa;
    r.ack = sa;
    r.npulse = np;
    r.opt = o;
    f = '0;
    f.kind = r.kind;
    f.seq_is_recv = (m == 2'h3);
    f.code = (k != 2'h0) ? c : (m == 2'h3) ? 7'h22 : 7'h11;
    f.octets = (k == 2'h2) ? 3'(3'h3 + {1'b0, o}) : 3'h3;
    if (o != 2'h0) f.dur = 5'h0a;
    if (o != 2'h0) f.supp = sa;
    if (o == 2'h2) f.ack = sa;
    if (o == 2'h2) f.npulse = np;
    xq.delete();
    aq.delete();
    @(posedge clk);
    if (fa) a_tx <= r;
    else x_tx <= r;
    a_req <= fa;
    x_req <= !fa;
    x_msg <= r.msg;
    a_msg <= r.msg;
    @(posedge clk);
    x_req <= 1'b0;
    a_req <= 1'b0;
    #1;
    chk((fa ? a_rej : x_rej) === rj, "refusal wrong");
    if (!rj) begin
      wv(fa ? 0 : 1);
      q = fa ? aq : xq;
      chk((fa ? x_rv : a_rv) === 1'b1 && (fa ? x_re : a_re) === 1'b0, "no clean element");
      chk((fa ? x_rf : a_rf) === f, "fields wrong");
      chk(q.size() == f.octets && q[0] === {6'h00, k} && q[2] === {1'b1, f.code}
          && q[1] === {5'h00, 3'(f.octets - 3'h2)}, "wire head wrong");
      if (o != 2'h0) chk(q[3] === {(o == 2'h1), sa, 5'h0a}, "octet four wrong");
      if (o == 2'h2) chk(q[4] === {1'b1, sa, np}, "octet 4a wrong");
    end
  endtask
  // raw octets, first in the top byte, into the faulty link
  task automatic inj(input int n, input logic [39:0] b, input logic [1:0] m, input logic e);
    b_msg <= pstn_ie_pkg::msg_class_t'(m);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      lk2.a2x_valid <= 1'b1;
      lk2.a2x_data <= b[39 - 8 * i -: 8];
      lk2.a2x_last <= (i == n - 1);
    end
    @(posedge clk);
    // released line shows the inverse, never a stale copy
    lk2.a2x_valid <= 1'b0;
    lk2.a2x_data <= ~b[39 - 8 * (n - 1) -: 8];
    lk2.a2x_last <= 1'b0;
    wv(2);
    chk(b_rv === 1'b1 && b_re === e, "receive check wrong");
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    x_req = 1'b0;
    a_req = 1'b0;
    x_tx = '0;
    a_tx = '0;
    x_msg = pstn_ie_pkg::MSG_SIGNAL;
    a_msg = pstn_ie_pkg::MSG_SIGNAL;
    b_msg = pstn_ie_pkg::MSG_SIGNAL;
    lk2.a2x_valid = 1'b0;
    lk2.a2x_data = 8'h00;
    lk2.a2x_last = 1'b0;
    lk2.x2a_ready = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(x_rdy === 1'b1 && a_rdy === 1'b1 && x_rv === 1'b0, "reset state");
    // class 2 is the not-allowed one
    for (int m = 0; m < 4; m++) begin
      run(1'b0, 2'h0, 2'(m), 7'h00, 2'h0, 5'h00, 2'h0, m == 2);
      run(1'b1, 2'h0, 2'(m), 7'h00, 2'h0, 5'h00, 2'h0, m == 2);
    end
    $display("test sequence done");
    run(1'b0, 2'h1, 2'h0, 7'h5a, 2'h0, 5'h00, 2'h0, 1'b0);
    run(1'b1, 2'h1, 2'h0, 7'h5a, 2'h0, 5'h00, 2'h0, 1'b1);
    $display("test ringing done");
    for (int s = 0; s < 4; s++) begin
      run(s[0], 2'h2, 2'h0, 7'(7'h7f - s), 2'h2, 5'h1f, 2'(s), 1'b0);
    end
    run(1'b0, 2'h2, 2'h0, 7'h6b, 2'h0, 5'h01, 2'h0, 1'b0);
    run(1'b1, 2'h2, 2'h0, 7'h6b, 2'h1, 5'h01, 2'h3, 1'b0);
    run(1'b0, 2'h2, 2'h0, 7'h6a, 2'h0, 5'h01, 2'h0, 1'b1);
    run(1'b0, 2'h2, 2'h0, 7'h7f, 2'h3, 5'h01, 2'h0, 1'b1);
    run(1'b1, 2'h2, 2'h0, 7'h7f, 2'h2, 5'h00, 2'h0, 1'b1);
    $display("test pulsed done");
    for (int i = 0; i < 7; i++) begin
      run(i[0], 2'h3, 2'h0, st[i][6:0], 2'h0, 5'h00, 2'h0, st[i][7]);
    end
    $display("test steady done");
    inj(3, 40'h01_0185_0000, 2'h0, 1'b1);
    inj(3, 40'h00_0185_0000, 2'h2, 1'b1);
    inj(3, 40'h00_0185_0000, 2'h3, 1'b0);
    chk(b_rf.seq_is_recv === 1'b1 && b_rf.code === 7'h05, "sequence fields");
    inj(5, 40'h02_03ff_0a80, 2'h0, 1'b1);
    inj(5, 40'h02_03ff_2a83, 2'h0, 1'b0);
    chk(b_rf.npulse === 5'h03 && b_rf.supp === 2'h1 && b_rf.octets === 3'h5, "pulse fields");
    inj(2, 40'h03_0000_0000, 2'h0, 1'b1);
    inj(3, 40'h03_019b_0000, 2'h0, 1'b1);
    inj(4, 40'h02_02ea_0a00, 2'h0, 1'b1);
    inj(3, 40'h02_017f_0000, 2'h0, 1'b1);
    $display("test receive faults done");
    close_out();
  end
endmodule // pstn_variable_ie_codec_tb
`default_nettype wire
